// File: core/ioxc_top.sv
// Expander core: input scan, outputs, logic, reset, pulse, interrupt pin, serial slave
`timescale 1ns/1ps
module ioxc_top
  import ioxc_pkg::*;
#(
  parameter int MS_CYC = TICK_MS * 1000 * CLK_MHZ
)(
  input  wire logic       CLK,
  input  wire logic       NRST,
  input  wire logic       LCLK,
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  input  wire logic [9:0] IO_I,
  input  wire logic       RST_I,
  output logic            SDA_O,
  output logic            SDA_OE,
  output logic            INT_O,
  output logic            INT_OE,
  output logic [9:0]      IO_O,
  output logic [9:0]      IO_OE
);
  initial if (MS_CYC < 2 || MS_CYC > 65535) $error("MS_CYC out of range");
  logic [1:0] rs, lrs, hold_s, scl_s, sda_s;
  logic [2:0] rq_s, ak_s;
  logic       rst_n, lrst_n, scl_p, sda_p;
  assign rst_n  = rs[1];
  assign lrst_n = lrs[1];
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST) rs <= 2'h0;
    else rs <= {rs[0], 1'b1};
  always_ff @(posedge LCLK or negedge NRST)
    if (!NRST) lrs <= 2'h0;
    else lrs <= {lrs[0], 1'b1};
  // Link side: serial slave on the link clock
  ioxc_link_e st;
  logic [3:0] bc;
  logic [7:0] sh, ptr, tx, l_a, l_d;
  logic       ackph, rw, l_we, l_rq, busy, lhold;
  logic [7:0] rdat;
  logic       ak_t;
  wire start = scl_s[1] && sda_p && !sda_s[1];
  wire stop  = scl_s[1] && !sda_p && sda_s[1];
  wire srise = scl_s[1] && !scl_p;
  wire sfall = !scl_s[1] && scl_p;
  always_ff @(posedge LCLK or negedge lrst_n)
    if (!lrst_n)
    begin
      scl_s <= 2'h3; sda_s <= 2'h3; scl_p <= 1'b1; sda_p <= 1'b1; ak_s <= 3'h0;
    end
    else
    begin
      scl_s <= {scl_s[0], SCL_I}; sda_s <= {sda_s[0], SDA_I};
      scl_p <= scl_s[1]; sda_p <= sda_s[1]; ak_s <= {ak_s[1:0], ak_t};
    end
  always_ff @(posedge LCLK or negedge lrst_n)
    if (!lrst_n)
    begin
      st <= L_IDLE; bc <= 4'h0; sh <= 8'h00; ptr <= 8'h00; tx <= 8'h00; ackph <= 1'b0;
      rw <= 1'b0; l_we <= 1'b0; l_rq <= 1'b0; l_a <= 8'h00; l_d <= 8'h00;
      busy <= 1'b0; SDA_OE <= 1'b0; SDA_O <= 1'b0; lhold <= 1'b0;
    end
    else
    begin
      lhold <= (st != L_IDLE) && (ptr == A_STAT || ptr == A_FIFO);
      if (ak_s[2] != ak_s[1]) busy <= 1'b0;
      if (start)
      begin
        st <= L_ADDR; bc <= 4'h0; ackph <= 1'b0; SDA_OE <= 1'b0;
      end
      else if (stop)
      begin
        st <= L_IDLE; SDA_OE <= 1'b0; ackph <= 1'b0;
      end
      else if (st != L_IDLE && srise)
      begin
        if (ackph && st == L_RD && !sda_s[1] && !busy)
        begin
          l_we <= 1'b0; l_a <= ptr; ptr <= ptr + 8'h01; l_rq <= !l_rq; busy <= 1'b1;
        end
        if (ackph && st == L_RD && sda_s[1]) st <= L_IDLE;
        if (!ackph)
        begin
          sh <= {sh[6:0], sda_s[1]}; bc <= bc + 4'h1;
        end
      end
      else if (st != L_IDLE && sfall)
      begin
        if (bc == 4'h8 && !ackph)
        begin
          ackph <= 1'b1; bc <= 4'h0; SDA_OE <= 1'b0;
          unique case (st)
            L_ADDR:
              if (sh[7:1] == DEV_ADDR)
              begin
                SDA_OE <= 1'b1; rw <= sh[0];
                if (sh[0] && !busy)
                begin
                  l_we <= 1'b0; l_a <= ptr; ptr <= ptr + 8'h01; l_rq <= !l_rq; busy <= 1'b1;
                end
              end
              else st <= L_IDLE;
            L_PTR:
            begin
              SDA_OE <= 1'b1; ptr <= sh;
            end
            L_WR:
            begin
              SDA_OE <= 1'b1;
              if (!busy)
              begin
                l_we <= 1'b1; l_a <= ptr; l_d <= sh; l_rq <= !l_rq; busy <= 1'b1;
              end
              ptr <= ptr + 8'h01;
            end
            L_RD: SDA_OE <= 1'b0;
            default: st <= L_IDLE;
          endcase
        end
        else if (ackph)
        begin
          ackph <= 1'b0; SDA_OE <= 1'b0;
          if (st == L_ADDR) st <= rw ? L_RD : L_PTR;
          else if (st == L_PTR) st <= L_WR;
          if ((st == L_ADDR && rw) || st == L_RD)
          begin
            SDA_OE <= !rdat[7]; tx <= {rdat[6:0], 1'b0};
          end
        end
        else if (st == L_RD)
        begin
          SDA_OE <= !tx[7]; tx <= {tx[6:0], 1'b0};
        end
      end
    end
  // Core side: request crossing and register file
  logic       go;
  logic [7:0] top, pol_l, pol_h, evn_l, evn_h, ien_l, ien_h, dat_l, dat_h;
  logic [7:0] oen_l, oen_h, ine_l, ine_h, rcfg, pgcfg, intbeh, intmsk, lcfg;
  logic [7:0] rtrg [3];
  logic [7:0] dly [2];
  logic [7:0] prd [2];
  logic [7:0] ont [2];
  logic [9:0] gfl, io_s1, io_s2, io_st;
  logic [4:0] ec, pend;
  logic [11:0] deb;
  logic       lout, rst_s1, rst_s2, rst_out_n;
  logic [1:0] pg;
  logic [7:0] rmux;
  assign go = rq_s[2] != rq_s[1];
  wire wr = go && l_we;
  wire rd = go && !l_we;
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      rq_s <= 3'h0; hold_s <= 2'h0; ak_t <= 1'b0; rdat <= 8'h00;
    end
    else
    begin
      rq_s <= {rq_s[1:0], l_rq}; hold_s <= {hold_s[0], lhold};
      if (go) ak_t <= !ak_t;
      if (rd) rdat <= rmux;
    end
  always_comb
  begin
    rmux = 8'h00;
    unique case (l_a)
      A_TOP:    rmux = top;
      A_STAT:   rmux = {1'b0, lout, 1'b0, ec};
      A_GFL_L:  rmux = gfl[7:0];
      A_GFL_H:  rmux = {6'h00, gfl[9:8]};
      A_LVL_L:  rmux = io_st[7:0] & ine_l;
      A_LVL_H:  rmux = {6'h00, io_st[9:8] & ine_h[1:0]};
      A_POL_L:  rmux = pol_l;
      A_POL_H:  rmux = pol_h;
      A_EVN_L:  rmux = evn_l;
      A_EVN_H:  rmux = evn_h;
      A_IEN_L:  rmux = ien_l;
      A_IEN_H:  rmux = ien_h;
      A_DAT_L:  rmux = dat_l;
      A_DAT_H:  rmux = dat_h;
      A_OEN_L:  rmux = oen_l;
      A_OEN_H:  rmux = oen_h;
      A_INE_L:  rmux = ine_l;
      A_INE_H:  rmux = ine_h;
      A_RTRG0:  rmux = rtrg[0];
      8'h2c:    rmux = rtrg[1];
      8'h2d:    rmux = rtrg[2];
      A_RCFG:   rmux = rcfg;
      A_DLY1:   rmux = dly[0];
      A_PRD1:   rmux = prd[0];
      A_ON1:    rmux = ont[0];
      A_DLY2:   rmux = dly[1];
      A_PRD2:   rmux = prd[1];
      A_ON2:    rmux = ont[1];
      A_PGCFG:  rmux = pgcfg;
      A_INTBEH: rmux = intbeh;
      A_INTMSK: rmux = intmsk;
      A_LOGIC:  rmux = lcfg;
      default:  rmux = 8'h00;
    endcase
  end
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      pol_l <= RST_VAL; pol_h <= RST_VAL; evn_l <= RST_VAL; evn_h <= RST_VAL;
      ien_l <= RST_VAL; ien_h <= RST_VAL; dat_l <= RST_VAL; dat_h <= RST_VAL;
      oen_l <= RST_VAL; oen_h <= RST_VAL; ine_l <= RST_VAL; ine_h <= RST_VAL;
      rcfg <= RST_VAL; pgcfg <= RST_VAL; intbeh <= RST_VAL; intmsk <= RST_VAL;
      lcfg <= RST_VAL;
      for (int i = 0; i < 3; i++) rtrg[i] <= RST_VAL;
      for (int i = 0; i < 2; i++)
      begin
        dly[i] <= RST_VAL; prd[i] <= RST_VAL; ont[i] <= RST_VAL;
      end
    end
    else if (wr)
    begin
      unique case (l_a)
        A_POL_L:  pol_l <= l_d;
        A_POL_H:  pol_h <= l_d;
        A_EVN_L:  evn_l <= l_d;
        A_EVN_H:  evn_h <= l_d;
        A_IEN_L:  ien_l <= l_d;
        A_IEN_H:  ien_h <= l_d;
        A_DAT_L:  dat_l <= l_d;
        A_DAT_H:  dat_h <= l_d;
        A_OEN_L:  oen_l <= l_d;
        A_OEN_H:  oen_h <= l_d;
        A_INE_L:  ine_l <= l_d;
        A_INE_H:  ine_h <= l_d;
        A_RTRG0:  rtrg[0] <= l_d;
        8'h2c:    rtrg[1] <= l_d;
        8'h2d:    rtrg[2] <= l_d;
        A_RCFG:   rcfg <= l_d;
        A_DLY1:   dly[0] <= l_d;
        A_PRD1:   prd[0] <= l_d;
        A_ON1:    ont[0] <= l_d;
        A_DLY2:   dly[1] <= l_d;
        A_PRD2:   prd[1] <= l_d;
        A_ON2:    ont[1] <= l_d;
        A_PGCFG:  pgcfg <= l_d;
        A_INTBEH: intbeh <= l_d;
        A_INTMSK: intmsk <= l_d;
        A_LOGIC:  lcfg <= l_d;
        default:  ;
      endcase
    end
  // Input scanner: one debounce window, then a single update
  wire [9:0] ine = {ine_h[1:0], ine_l};
  wire [9:0] pol = {pol_h[1:0], pol_l};
  wire [9:0] evn = {evn_h[1:0], evn_l} & ine;
  wire [9:0] ien = {ien_h[1:0], ien_l};
  wire       upd = (io_s2 != io_st) && deb == 12'(DEB_CYC - 1);
  wire [9:0] rise = upd ? (io_s2 & ~io_st & ine) : 10'h000;
  wire [9:0] fall = upd ? (~io_s2 & io_st & ine) : 10'h000;
  wire [9:0] trig = ((rise & pol) | (fall & ~pol)) & ien & ~evn;
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      io_s1 <= 10'h000; io_s2 <= 10'h000; io_st <= 10'h000; deb <= 12'h000;
      rst_s1 <= 1'b1; rst_s2 <= 1'b1;
    end
    else
    begin
      io_s1 <= IO_I; io_s2 <= io_s1; rst_s1 <= RST_I; rst_s2 <= rst_s1;
      if (io_s2 == io_st) deb <= 12'h000;
      else if (upd)
      begin
        io_st <= io_s2; deb <= 12'h000;
      end
      else deb <= deb + 12'h001;
    end
  // Logic block on rows 1-3, result on row 0
  logic       lnew, lq;
  logic [3:0] nev;
  logic [5:0] sum;
  wire  [2:0] lin = io_st[3:1] & ine[3:1];
  always_comb
  begin
    unique case (lcfg[1:0])
      2'h0:    lnew = &lin;
      2'h1:    lnew = |lin;
      default: lnew = ^lin;
    endcase
    lnew = lnew ^ lcfg[2];
  end
  wire lchg = lnew != lq;
  wire lev = lchg && lcfg[4];
  always_comb
  begin
    nev = 4'h0;
    for (int i = 0; i < LINES; i++) nev = nev + 4'((rise[i] | fall[i]) & evn[i]);
    nev = nev + 4'(lev);
    sum = 6'(ec) + 6'(pend) + 6'(nev) - 6'(rd && l_a == A_FIFO && ec != 5'h00);
  end
  wire hold = hold_s[1];
  wire wtop = wr && l_a == A_TOP;
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      lq <= 1'b0; lout <= 1'b0; gfl <= 10'h000; top <= 8'h00; ec <= 5'h00; pend <= 5'h00;
    end
    else
    begin
      lq <= lnew; lout <= lq;
      gfl <= trig | (gfl & ~(rd && l_a == A_GFL_L ? 10'h0ff : 10'h000)
                          & ~(rd && l_a == A_GFL_H ? 10'h300 : 10'h000));
      if (hold)
      begin
        pend <= pend + 5'(nev);
        if (rd && l_a == A_FIFO && ec != 5'h00) ec <= ec - 5'h01;
      end
      else
      begin
        pend <= 5'h00;
        ec <= (sum > 6'(EC_MAX)) ? 5'(EC_MAX) : sum[4:0];
      end
      top[0] <= (!hold && (pend != 5'h00 || nev != 4'h0)) || (top[0] && !(wtop && l_d[0]));
      top[1] <= (|trig) || (top[1] && !(wtop && l_d[1]));
      top[2] <= (!hold && sum > 6'(EC_MAX)) || (top[2] && !(wtop && l_d[2]));
      top[3] <= (lchg && lcfg[3]) || (top[3] && !(wtop && l_d[3]));
    end
  // Time base and reset generator
  logic [15:0] msc, hcnt;
  logic [6:0]  c125;
  logic [4:0]  pw;
  logic        t1, t125, fired;
  logic [2:0]  tp;
  always_comb
    for (int i = 0; i < 3; i++)
      tp[i] = !rtrg[i][7] || (ine[rtrg[i][3:0]] && !io_st[rtrg[i][3:0]]);
  wire all_on = (rtrg[0][7] || rtrg[1][7] || rtrg[2][7]) && (&tp);
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      msc <= 16'h0000; c125 <= 7'h00; t1 <= 1'b0; t125 <= 1'b0;
      hcnt <= 16'h0000; pw <= 5'h00; fired <= 1'b0; rst_out_n <= 1'b1;
    end
    else
    begin
      t1 <= msc == 16'(MS_CYC - 1);
      msc <= (msc == 16'(MS_CYC - 1)) ? 16'h0000 : msc + 16'h0001;
      t125 <= t1 && c125 == 7'(COARSE - 1);
      if (t1) c125 <= (c125 == 7'(COARSE - 1)) ? 7'h00 : c125 + 7'h01;
      if (!all_on || !rcfg[0])
      begin
        hcnt <= 16'h0000; fired <= 1'b0;
      end
      else if (!fired && hcnt >= 16'(rcfg[5:2]) * 16'(HOLD_MS))
      begin
        fired <= 1'b1; pw <= 5'(RPW_MS);
      end
      else if (t1 && !fired) hcnt <= hcnt + 16'h0001;
      if (pw != 5'h00 && t1) pw <= pw - 5'h01;
      rst_out_n <= !(pw != 5'h00);
    end
  // Pulse generators
  for (genvar c = 0; c < 2; c++)
  begin : g_pg
    logic [7:0] dc, pc, oc;
    logic       run;
    wire en = pgcfg[4*c];
    wire pt = pgcfg[4*c+1] ? t125 : t1;
    wire ot = pgcfg[4*c+2] ? t125 : t1;
    always_ff @(posedge CLK or negedge rst_n)
      if (!rst_n)
      begin
        dc <= 8'h00; pc <= 8'h00; oc <= 8'h00; run <= 1'b0; pg[c] <= 1'b0;
      end
      else
      begin
        if (!en)
        begin
          dc <= dly[c]; pc <= 8'h00; oc <= 8'h00; run <= 1'b0;
        end
        else if (!run)
        begin
          if (dc == 8'h00) run <= 1'b1;
          else if (pt) dc <= dc - 8'h01;
        end
        else if (pt && (pc == prd[c] - 8'h01 || prd[c] == 8'h00))
        begin
          pc <= 8'h00; oc <= 8'h00;
        end
        else
        begin
          if (pt) pc <= pc + 8'h01;
          if (ot && oc != 8'hff) oc <= oc + 8'h01;
        end
        pg[c] <= (run && oc < ont[c]) ^ pgcfg[4*c+3];
      end
  end
  // Pin drivers and interrupt pin
  logic [3:0]  srcq;
  logic [11:0] gap;
  wire [3:0] src = top[3:0] & intmsk[3:0];
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      IO_O <= 10'h000; IO_OE <= 10'h000; INT_O <= 1'b0; INT_OE <= 1'b0;
      srcq <= 4'h0; gap <= 12'h000;
    end
    else
    begin
      IO_OE <= {oen_h[1:0], oen_l};
      IO_O <= {dat_h[1:0], dat_l};
      if (lcfg[5]) IO_O[0] <= lout;
      if (rcfg[1]) IO_O[4] <= rst_s2;
      else if (rcfg[0]) IO_O[4] <= rst_out_n;
      if (pgcfg[0]) IO_O[6] <= pg[0];
      if (pgcfg[4]) IO_O[7] <= pg[1];
      srcq <= src;
      if (intbeh[0] && |(srcq & ~src) && |src) gap <= 12'(GAP_CYC);
      else if (gap != 12'h000) gap <= gap - 12'h001;
      INT_OE <= |src && gap == 12'h000;
    end
  // Checks
  a_scan_idle: assert property (@(posedge CLK) disable iff (!rst_n)
    (io_s2 == io_st) |=> deb == 12'h000) else $error("scanner not idle");
  a_level_tracks: assert property (@(posedge CLK) disable iff (!rst_n)
    upd |=> io_st == $past(io_s2)) else $error("level not updated");
  a_flag_latch: assert property (@(posedge CLK) disable iff (!rst_n)
    (upd && |((io_s2 & ~io_st & ine & pol & ien & ~evn))) |=> |gfl) else $error("flag lost");
  a_summary_set: assert property (@(posedge CLK) disable iff (!rst_n)
    |trig |=> top[1]) else $error("summary not set");
  a_event_path: assert property (@(posedge CLK) disable iff (!rst_n)
    (|evn && !hold && nev != 4'h0) |=> top[0] && !$past(|trig & ~(|ien))) else $error("event flag");
  a_count_cap: assert property (@(posedge CLK) disable iff (!rst_n)
    ec <= 5'(EC_MAX)) else $error("counter above cap");
  a_hold_freeze: assert property (@(posedge CLK) disable iff (!rst_n)
    (hold && !rd) |=> $stable(ec)) else $error("counter moved while held");
  a_int_pin: assert property (@(posedge CLK) disable iff (!rst_n)
    (src == 4'h0) |=> !INT_OE) else $error("pin without source");
  a_gap_len: assert property (@(posedge CLK) disable iff (!rst_n)
    (gap == 12'h001) |=> gap == 12'h000 ##1 (INT_OE || $past(src) == 4'h0)) else $error("gap");
  a_oe_follow: assert property (@(posedge CLK) disable iff (!rst_n)
    1'b1 |=> IO_OE == $past({oen_h[1:0], oen_l})) else $error("oe mismatch");
  a_ack_addr: assert property (@(posedge LCLK) disable iff (!lrst_n)
    (sfall && st == L_ADDR && bc == 4'h8 && !ackph && sh[7:1] == DEV_ADDR) |=> SDA_OE)
    else $error("no address ack");
  c_gpi_irq: cover property (@(posedge CLK) disable iff (!rst_n) |trig);
  c_write: cover property (@(posedge CLK) disable iff (!rst_n) wr);
  c_gap: cover property (@(posedge CLK) disable iff (!rst_n) gap == 12'h001);
  c_reset: cover property (@(posedge CLK) disable iff (!rst_n) !rst_out_n);
endmodule

// File: core/ioxc_pkg.sv
// Shared offsets, reset values and timing constants of the expander core
package ioxc_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h34;
  localparam logic [7:0] A_TOP    = 8'h01;
  localparam logic [7:0] A_STAT   = 8'h02;
  localparam logic [7:0] A_FIFO   = 8'h03;
  localparam logic [7:0] A_GFL_L  = 8'h13;
  localparam logic [7:0] A_GFL_H  = 8'h14;
  localparam logic [7:0] A_LVL_L  = 8'h15;
  localparam logic [7:0] A_LVL_H  = 8'h16;
  localparam logic [7:0] A_POL_L  = 8'h1b;
  localparam logic [7:0] A_POL_H  = 8'h1c;
  localparam logic [7:0] A_EVN_L  = 8'h1d;
  localparam logic [7:0] A_EVN_H  = 8'h1e;
  localparam logic [7:0] A_IEN_L  = 8'h1f;
  localparam logic [7:0] A_IEN_H  = 8'h20;
  localparam logic [7:0] A_DAT_L  = 8'h23;
  localparam logic [7:0] A_DAT_H  = 8'h24;
  localparam logic [7:0] A_OEN_L  = 8'h27;
  localparam logic [7:0] A_OEN_H  = 8'h28;
  localparam logic [7:0] A_INE_L  = 8'h29;
  localparam logic [7:0] A_INE_H  = 8'h2a;
  localparam logic [7:0] A_RTRG0  = 8'h2b;
  localparam logic [7:0] A_RCFG   = 8'h2e;
  localparam logic [7:0] A_DLY1   = 8'h2f;
  localparam logic [7:0] A_PRD1   = 8'h30;
  localparam logic [7:0] A_ON1    = 8'h31;
  localparam logic [7:0] A_DLY2   = 8'h32;
  localparam logic [7:0] A_PRD2   = 8'h33;
  localparam logic [7:0] A_ON2    = 8'h34;
  localparam logic [7:0] A_PGCFG  = 8'h35;
  localparam logic [7:0] A_INTBEH = 8'h3d;
  localparam logic [7:0] A_INTMSK = 8'h3e;
  localparam logic [7:0] A_LOGIC  = 8'h40;
  localparam logic [7:0] RST_VAL  = 8'h00;
  localparam int CLK_MHZ  = 40;
  localparam int DEB_US   = 70;
  localparam int DEB_CYC  = DEB_US * CLK_MHZ;
  localparam int GAP_US   = 50;
  localparam int GAP_CYC  = GAP_US * CLK_MHZ;
  localparam int TICK_MS  = 1;
  localparam int COARSE   = 125;
  localparam int HOLD_MS  = 250;
  localparam int RPW_MS   = 10;
  localparam int EC_MAX   = 16;
  localparam int LINES    = 10;
  typedef enum logic [2:0] {
    L_IDLE = 3'b000, L_ADDR = 3'b001, L_PTR = 3'b010, L_WR = 3'b011, L_RD = 3'b100
  } ioxc_link_e;
endpackage

// File: tb/ioxc_host.sv
// Serial bus master model that reaches the expander registers
`timescale 1ns/1ps
module ioxc_host
  import ioxc_pkg::*;
#(
  parameter int HP = 400
)(
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda
);
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic bit_c(input logic b, output logic s);
    #50 sda = b;
    #(HP - 50) scl = 1'b1;
    s = sda_line;
    #HP scl = 1'b0;
  endtask
  task automatic start_c();
    #50 sda = 1'b1;
    #HP scl = 1'b1;
    #HP sda = 1'b0;
    #HP scl = 1'b0;
  endtask
  task automatic stop_c();
    #50 sda = 1'b0;
    #HP scl = 1'b1;
    #HP sda = 1'b1;
    #HP;
  endtask
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_c(d[i], s);
    bit_c(1'b1, s);
    ack = !s;
  endtask
  task automatic byte_in(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_c(1'b1, d[i]);
    bit_c(last, s);
  endtask
  task automatic head(input logic [7:0] a, output logic ok);
    logic k1;
    logic k2;
    start_c();
    byte_out({DEV_ADDR, 1'b0}, k1);
    byte_out(a, k2);
    ok = k1 & k2;
  endtask
  task automatic wr2(input logic [7:0] a, input logic [15:0] d, output logic ok);
    logic k0;
    logic k1;
    logic k2;
    head(a, k0);
    byte_out(d[7:0], k1);
    byte_out(d[15:8], k2);
    stop_c();
    ok = k0 & k1 & k2;
  endtask
  task automatic rd2(input logic [7:0] a, input logic two, output logic [15:0] d, output logic ok);
    logic k0;
    logic k1;
    head(a, k0);
    start_c();
    byte_out({DEV_ADDR, 1'b1}, k1);
    byte_in(!two, d[7:0]);
    if (two) byte_in(1'b1, d[15:8]);
    stop_c();
    ok = k0 & k1;
  endtask
endmodule

// File: tb/io_expander_control_core_tb.sv
// Self-checking bench of the expander core driven through its serial port
`timescale 1ns/1ps
module io_expander_control_core_tb;
  import ioxc_pkg::*;
  logic        clk;
  logic        lclk;
  logic        nrst;
  logic        rst_i;
  logic [9:0]  io_i;
  logic        sda_o;
  logic        sda_oe;
  logic        int_o;
  logic        int_oe;
  logic        scl;
  logic        sda_m;
  logic [9:0]  io_o;
  logic [9:0]  io_oe;
  logic        sda_w;
  logic [15:0] seed;
  logic [7:0]  regs [11];
  int          miscompares = 0;
  int          total_checks = 0;
  assign sda_w = sda_m & ~sda_oe;
  ioxc_top #(.MS_CYC(40)) dut (.CLK(clk), .NRST(nrst), .LCLK(lclk), .SCL_I(scl), .SDA_I(sda_w),
    .IO_I(io_i), .RST_I(rst_i), .SDA_O(sda_o), .SDA_OE(sda_oe), .INT_O(int_o), .INT_OE(int_oe),
    .IO_O(io_o), .IO_OE(io_oe));
  ioxc_host host (.sda_line(sda_w), .scl(scl), .sda(sda_m));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    lclk = 1'b0;
    #7;
    forever #16 lclk = ~lclk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test();
    if (miscompares == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.wr2(a, {d, d}, ok);
    chk("write ack", 1, ok);
  endtask
  task automatic w1(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.head(a, ok);
    host.byte_out(d, ok);
    host.stop_c();
    chk("write ack", 1, ok);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
    logic [15:0] d;
    logic        ok;
    host.rd2(a, 1'b0, d, ok);
    chk("read ack", 1, ok);
    chk(n, e, d[7:0] & m);
  endtask
  task automatic hi_count(input logic [15:0] e, input string n);
    logic [15:0] c;
    c = 0;
    repeat (640) @(posedge clk) c += io_o[6];
    chk(n, e, c);
  endtask
  initial
  begin
    cyc(100000);
    miscompares++;
    finish_test();
  end
  initial
  begin
    logic        ok;
    logic [15:0] d;
    logic [7:0]  r;
    nrst = 1'b0;
    rst_i = 1'b0;
    io_i = 10'h000;
    seed = 16'h3e93;
    regs = '{A_POL_L, A_EVN_L, A_IEN_L, A_OEN_L, A_INE_L, A_RCFG, A_PRD1, A_PRD2, A_PGCFG, A_INTBEH, A_INTMSK};
    cyc(3);
    nrst <= 1'b1;
    cyc(20);
    foreach (regs[i]) rd(regs[i], 8'hff, RST_VAL, "reset value");
    rd(8'h50, 8'hff, 8'h00, "unmapped");
    for (int i = 6; i < 8; i++)
    begin
      seed = lfsr(seed);
      w1(regs[i], seed[7:0]);
      rd(regs[i], 8'hff, seed[7:0], "rw reg");
    end
    host.start_c();
    host.byte_out({7'h35, 1'b0}, ok);
    host.stop_c();
    chk("foreign address ack", 0, ok);
    seed = lfsr(seed);
    r = seed[7:0] | 8'hc1;
    host.wr2(A_OEN_L, {8'h03, r}, ok);
    cyc(5);
    chk("output enables", {6'h00, 2'b11, r}, {6'h00, io_oe});
    host.rd2(A_OEN_L, 1'b1, d, ok);
    chk("two byte read", {8'h03, r}, d & 16'h03ff);
    w1(A_INE_L, 8'h0c);
    w1(A_POL_L, 8'h04);
    w1(A_IEN_L, 8'h04);
    w1(A_EVN_L, 8'h08);
    w1(A_INTMSK, 8'h0f);
    @(posedge clk) io_i <= 10'h02c;
    cyc(DEB_CYC + 100);
    rd(A_LVL_L, 8'hff, 8'h0c, "levels");
    chk("irq pin", 1, int_oe);
    rd(A_TOP, 8'h03, 8'h03, "top status");
    rd(A_STAT, 8'h1f, 8'h01, "event count");
    rd(A_GFL_L, 8'hff, 8'h04, "line flags");
    rd(A_GFL_L, 8'hff, 8'h00, "flags after read");
    rd(A_FIFO, 8'h00, 8'h00, "queue read");
    rd(A_STAT, 8'h1f, 8'h00, "count after read");
    w1(A_TOP, 8'h03);
    rd(A_TOP, 8'h03, 8'h00, "top cleared");
    cyc(5);
    chk("irq pin released", 0, int_oe);
    @(posedge clk) io_i <= 10'h028;
    cyc(DEB_CYC + 100);
    rd(A_GFL_L, 8'hff, 8'h00, "falling edge ignored");
    rd(A_LVL_L, 8'hff, 8'h08, "levels after fall");
    @(posedge clk) io_i <= 10'h020;
    cyc(DEB_CYC + 200);
    @(posedge clk) io_i <= 10'h028;
    cyc(DEB_CYC + 100);
    rd(A_STAT, 8'h1f, 8'h02, "pulse both edges");
    w1(A_PRD1, 8'h04);
    w1(A_ON1, 8'h01);
    w1(A_PGCFG, 8'h01);
    cyc(200);
    hi_count(16'd160, "pulse high time");
    w1(A_PGCFG, 8'h09);
    cyc(10);
    hi_count(16'd480, "inverted pulse");
    w1(A_LOGIC, 8'h29);
    cyc(5);
    chk("logic on row0", 1, io_o[0]);
    rd(A_TOP, 8'h08, 8'h08, "logic irq");
    rd(A_STAT, 8'h40, 8'h40, "logic state");
    w1(A_RTRG0, 8'h83);
    w1(A_RCFG, 8'h01);
    @(posedge clk) io_i <= 10'h020;
    cyc(DEB_CYC + 20);
    chk("reset pulse low", 0, io_o[4]);
    cyc(500);
    chk("reset pulse end", 1, io_o[4]);
    w1(A_RCFG, 8'h02);
    @(posedge clk) rst_i <= 1'b1;
    cyc(5);
    chk("reset pass high", 1, io_o[4]);
    @(posedge clk) rst_i <= 1'b0;
    cyc(5);
    chk("reset pass low", 0, io_o[4]);
    w1(A_INTBEH, 8'h01);
    w1(A_TOP, 8'h01);
    chk("irq gap", 0, int_oe);
    cyc(GAP_CYC);
    chk("irq reassert", 1, int_oe);
    finish_test();
  end
endmodule
